// ---- rtl/ubcm_top.sv ----
// Break-condition matcher: register file, per-instruction comparison and break request.
// Assumes bus-cycle and instruction-boundary reports come from logic on the same clock.
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`include "ubcm_params.svh"

// Overview of operation
// - Condition register clears on reset, hardware standby
// - Upper condition bits read zero, writes ignored
// - Source field: off, core, DMA, both
// - Fetch/data field: off, fetch, data, both
// - Direction field: off, read, write, both
// - Size field: any, byte, word, longword
// - Zero source, fetch/data or direction selector blocks every break
// - Fetches compare as word size
// - Data size is operand size, not port
// - Full match raises break request
// - Priority 15; taken only at mask <=14
// - Paired fetch compares each instruction separately
// - Fetch break precedes instruction; saves its address
// - Non-accepting instruction defers break; saves next
// - Data break saves next executed instruction
// - Fetch with write-only never breaks
// - Break address split into two halves
// - Mask bit one excludes address bit
module ubcm_top
  import ubcm_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        hw_standby,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  // Observed bus cycles
  input  wire ubcm_cycle_t bus_cycle,
  // Core instruction boundary
  input  wire ubcm_exec_t  exec,
  input  wire logic [3:0]  interrupt_mask_level,
  // Toward the interrupt controller
  output logic             brk_req,
  output logic [3:0]       brk_prio,
  output logic             brk_take,
  output logic [31:0]      saved_pc
);

  logic [15:0]   addr_hi_q;
  logic [15:0]   addr_lo_q;
  logic [15:0]   mask_hi_q;
  logic [15:0]   mask_lo_q;
  logic [7:0]    cond_q;
  ubcm_cond_t    cond;
  logic [31:0]   brk_addr;
  logic [31:0]   brk_mask;
  logic [31:0]   slot_addr [2];
  logic [1:0]    slot_hit;
  logic          any_hit;
  logic [31:0]   hit_addr;
  logic [15:0]   rdata_d;
  ubcm_hold_st_t hold_st;
  logic          tgt_fetch;
  logic          reg_clear;

  // Hardware standby clears like reset; software standby is not seen here
  assign reg_clear = reset | hw_standby;

  // Break address and mask registers
  always_ff @(posedge clk) begin
    if (reg_clear) begin
      addr_hi_q <= `UBCM_RST_16;
      addr_lo_q <= `UBCM_RST_16;
      mask_hi_q <= `UBCM_RST_16;
      mask_lo_q <= `UBCM_RST_16;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `UBCM_OFF_ADDR_HI: addr_hi_q <= reg_wdata;
        `UBCM_OFF_ADDR_LO: addr_lo_q <= reg_wdata;
        `UBCM_OFF_MASK_HI: mask_hi_q <= reg_wdata;
        `UBCM_OFF_MASK_LO: mask_lo_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Condition register; only the low byte is stored
  always_ff @(posedge clk) begin
    if (reg_clear) begin
      cond_q <= 8'(`UBCM_RST_16);
    end else if (reg_wr && reg_addr == `UBCM_OFF_COND) begin
      cond_q <= reg_wdata[7:0];
    end
  end

  assign cond.cycle_source_sel = cond_q[`UBCM_COND_SRC_HI:`UBCM_COND_SRC_LO];
  assign cond.fetch_data_sel   = cond_q[`UBCM_COND_FD_HI:`UBCM_COND_FD_LO];
  assign cond.direction_sel    = cond_q[`UBCM_COND_DIR_HI:`UBCM_COND_DIR_LO];
  assign cond.size_sel         = cond_q[`UBCM_COND_SZ_HI:`UBCM_COND_SZ_LO];
  assign brk_addr = {addr_hi_q, addr_lo_q};
  assign brk_mask = {mask_hi_q, mask_lo_q};

  // Read mux; unmapped offsets and reserved bits read zero
  always_comb begin
    rdata_d = 16'h0000;
    unique case (reg_addr)
      `UBCM_OFF_ADDR_HI: rdata_d = addr_hi_q;
      `UBCM_OFF_ADDR_LO: rdata_d = addr_lo_q;
      `UBCM_OFF_MASK_HI: rdata_d = mask_hi_q;
      `UBCM_OFF_MASK_LO: rdata_d = mask_lo_q;
      `UBCM_OFF_COND:    rdata_d = {8'h00, cond_q};
      `UBCM_OFF_STATUS:  rdata_d = {13'h0000, tgt_fetch, hold_st == UBCM_DEFER, brk_req};
      default:           rdata_d = 16'h0000;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= `UBCM_RST_16;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= `UBCM_RST_16;
    end
  end

  // Two instruction slots: a paired on-chip fetch is two independent compares
  assign slot_addr[0] = (bus_cycle.fetch && bus_cycle.pair) ?
                        {bus_cycle.addr[31:2], 2'h0} : bus_cycle.addr;
  assign slot_addr[1] = {bus_cycle.addr[31:2], `UBCM_PAIR_OFF};

  for (genvar s = 0; s < 2; s++) begin : g_slot
    logic slot_en;
    logic slot_raw;
    // Second slot only exists for paired fetches
    assign slot_en = (s == 0) || (bus_cycle.fetch && bus_cycle.pair);
    ubcm_match u_match (
      .cond     (cond),
      .brk_addr (brk_addr),
      .brk_mask (brk_mask),
      .cyc      (bus_cycle),
      .cmp_addr (slot_addr[s]),
      .hit      (slot_raw)
    );
    assign slot_hit[s] = slot_en & slot_raw;
  end

  // First instruction wins when both slots match; it executes first anyway
  assign any_hit  = |slot_hit;
  assign hit_addr = slot_hit[0] ? slot_addr[0] : slot_addr[1];

  ubcm_hold u_hold (
    .clk         (clk),
    .reset       (reset),
    .clear       (hw_standby),
    .hit         (any_hit),
    .hit_fetch   (bus_cycle.fetch),
    .hit_addr    (hit_addr),
    .exec        (exec),
    .mask_level  (interrupt_mask_level),
    .brk_req     (brk_req),
    .brk_take    (brk_take),
    .saved_pc_q  (saved_pc),
    .state_q     (hold_st),
    .tgt_fetch_q (tgt_fetch)
  );

  // Fixed request priority
  assign brk_prio = `UBCM_PRIO;

  // Checks

  property p_cond_clear;
    @(posedge clk) reg_clear |=> cond_q == 8'h00;
  endproperty
  a_cond_clear: assert property (p_cond_clear)
    else $error("condition register not cleared");

  property p_reserved_zero;
    @(posedge clk) disable iff (reset)
      reg_rd && reg_addr == `UBCM_OFF_COND |=> reg_rdata[15:8] == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved condition bits read nonzero");

  property p_sel_off_blocks;
    @(posedge clk) disable iff (reset)
      (cond.cycle_source_sel == 2'h0 || cond.fetch_data_sel == 2'h0 ||
       cond.direction_sel == 2'h0) |-> !any_hit;
  endproperty
  a_sel_off_blocks: assert property (p_sel_off_blocks)
    else $error("break raised with a selector off");

  property p_src_select;
    @(posedge clk) disable iff (reset)
      any_hit |-> (bus_cycle.dma ? cond.cycle_source_sel[1] : cond.cycle_source_sel[0]);
  endproperty
  a_src_select: assert property (p_src_select)
    else $error("hit from an unselected source");

  property p_fetch_never_write;
    @(posedge clk) disable iff (reset)
      (bus_cycle.fetch && cond.direction_sel == 2'h2) |-> !any_hit;
  endproperty
  a_fetch_never_write: assert property (p_fetch_never_write)
    else $error("fetch matched a write-only condition");

  property p_size_match;
    @(posedge clk) disable iff (reset)
      (any_hit && cond.size_sel != 2'h0) |->
        cond.size_sel == (bus_cycle.fetch ? 2'h2 : bus_cycle.size);
  endproperty
  a_size_match: assert property (p_size_match)
    else $error("hit with the wrong operand size");

  property p_hit_raises_req;
    @(posedge clk) disable iff (reset || hw_standby)
      (any_hit && !brk_req) |=> brk_req;
  endproperty
  a_hit_raises_req: assert property (p_hit_raises_req)
    else $error("match did not raise a request");

  property p_level15_holds;
    @(posedge clk) disable iff (reset || hw_standby)
      (brk_req && interrupt_mask_level == 4'hF) |-> !brk_take ##1 brk_req;
  endproperty
  a_level15_holds: assert property (p_level15_holds)
    else $error("request lost or taken at mask level 15");

  property p_take_saves_pc;
    @(posedge clk) disable iff (reset || hw_standby)
      brk_take |=> saved_pc == $past(exec.pc) && !brk_req;
  endproperty
  a_take_saves_pc: assert property (p_take_saves_pc)
    else $error("saved program counter wrong after take");

  property p_defer_not_at_target;
    @(posedge clk) disable iff (reset || hw_standby)
      (hold_st == UBCM_PEND && tgt_fetch && exec.valid && !exec.int_ok) |-> !brk_take;
  endproperty
  a_defer_not_at_target: assert property (p_defer_not_at_target)
    else $error("break taken on a non-accepting instruction");

  // Single-slot cycles: every unmasked address bit must agree with the break address
  property p_addr_mask;
    @(posedge clk) disable iff (reset)
      (any_hit && !(bus_cycle.fetch && bus_cycle.pair)) |->
        ((bus_cycle.addr ^ brk_addr) & ~brk_mask) == 32'h0000_0000;
  endproperty
  a_addr_mask: assert property (p_addr_mask)
    else $error("hit with an unmasked address bit differing");

  property p_fd_select;
    @(posedge clk) disable iff (reset)
      any_hit |-> (bus_cycle.fetch ? cond.fetch_data_sel[0] : cond.fetch_data_sel[1]);
  endproperty
  a_fd_select: assert property (p_fd_select)
    else $error("hit on an unselected fetch or data cycle");

  // A fetch counts as a read whatever the write flag says
  property p_dir_select;
    @(posedge clk) disable iff (reset)
      any_hit |-> ((bus_cycle.write && !bus_cycle.fetch) ?
                   cond.direction_sel[1] : cond.direction_sel[0]);
  endproperty
  a_dir_select: assert property (p_dir_select)
    else $error("hit on an unselected direction");

  property p_fetch_word;
    @(posedge clk) disable iff (reset)
      (any_hit && bus_cycle.fetch) |-> (cond.size_sel == 2'h0 || cond.size_sel == 2'h2);
  endproperty
  a_fetch_word: assert property (p_fetch_word)
    else $error("fetch matched a byte or longword size");

  property p_valid_only;
    @(posedge clk) disable iff (reset)
      !bus_cycle.valid |-> !any_hit;
  endproperty
  a_valid_only: assert property (p_valid_only)
    else $error("hit without a valid bus cycle");

  property p_take_level;
    @(posedge clk) disable iff (reset || hw_standby)
      brk_take |-> interrupt_mask_level <= 4'hE;
  endproperty
  a_take_level: assert property (p_take_level)
    else $error("break taken above mask level 14");

  property p_take_accepting;
    @(posedge clk) disable iff (reset || hw_standby)
      brk_take |-> (exec.valid && exec.int_ok);
  endproperty
  a_take_accepting: assert property (p_take_accepting)
    else $error("break taken off an accepting boundary");

  // Only the low byte is kept; the upper byte reads back as zero
  property p_cond_write;
    @(posedge clk) disable iff (reg_clear)
      (reg_wr && reg_addr == `UBCM_OFF_COND) |=> cond_q == $past(reg_wdata[7:0]);
  endproperty
  a_cond_write: assert property (p_cond_write)
    else $error("condition write not stored");

  // Once raised, the request only drops through a take, reset or hardware standby
  property p_req_until_take;
    @(posedge clk) disable iff (reset || hw_standby)
      (brk_req && !brk_take) |=> brk_req;
  endproperty
  a_req_until_take: assert property (p_req_until_take)
    else $error("request dropped without a take");

endmodule

// ---- rtl/ubcm_params.svh ----
// Register offsets, field positions, reset values and interrupt levels for the break matcher.
// Assumes byte offsets on a 16-bit plain register port.
`ifndef UBCM_PARAMS_SVH
`define UBCM_PARAMS_SVH

// Register offsets
`define UBCM_OFF_ADDR_HI    4'h0
`define UBCM_OFF_ADDR_LO    4'h2
`define UBCM_OFF_MASK_HI    4'h4
`define UBCM_OFF_MASK_LO    4'h6
`define UBCM_OFF_COND       4'h8
`define UBCM_OFF_STATUS     4'hA

// Reset values
`define UBCM_RST_16         16'h0000
`define UBCM_RST_32         32'h0000_0000

// Condition register fields
`define UBCM_COND_SRC_HI    7
`define UBCM_COND_SRC_LO    6
`define UBCM_COND_FD_HI     5
`define UBCM_COND_FD_LO     4
`define UBCM_COND_DIR_HI    3
`define UBCM_COND_DIR_LO    2
`define UBCM_COND_SZ_HI     1
`define UBCM_COND_SZ_LO     0
`define UBCM_COND_WMASK     16'h00FF

// Size codes and selector codes
`define UBCM_SZ_ANY         2'h0
`define UBCM_SZ_WORD        2'h2
`define UBCM_SEL_OFF        2'h0

// Interrupt priority and highest accepting mask level
`define UBCM_PRIO           4'hF
`define UBCM_MASK_MAX_OK    4'hE

// Offset of the second instruction of a paired on-chip fetch
`define UBCM_PAIR_OFF       2'h2

`endif

// ---- rtl/ubcm_pkg.sv ----
// Types shared by the break matcher modules.
// Assumes ubcm_params.svh supplies all numeric constants.
package ubcm_pkg;

  // One observed bus cycle
  typedef struct packed {
    logic        valid;
    logic        dma;    // 1: DMA or transfer controller, 0: core
    logic        fetch;  // 1: instruction fetch, 0: data access
    logic        write;
    logic [1:0]  size;   // 1 byte, 2 word, 3 longword
    logic        pair;   // Fetch carries two instructions
    logic [31:0] addr;
  } ubcm_cycle_t;

  // Decoded condition fields
  typedef struct packed {
    logic [1:0] cycle_source_sel;
    logic [1:0] fetch_data_sel;
    logic [1:0] direction_sel;
    logic [1:0] size_sel;
  } ubcm_cond_t;

  // Instruction boundary seen by the hold logic
  typedef struct packed {
    logic        valid;
    logic        int_ok; // Instruction may accept an interrupt
    logic [31:0] pc;     // Address of the instruction about to execute
  } ubcm_exec_t;

  typedef enum logic [1:0] {UBCM_IDLE, UBCM_PEND, UBCM_DEFER} ubcm_hold_st_t;

endpackage

// ---- rtl/ubcm_match.sv ----
// Combinational comparison of one instruction or access address against the break condition.
// Assumes the caller supplies the attributes of the same bus cycle.
`timescale 1ns/1ps
`include "ubcm_params.svh"

module ubcm_match
  import ubcm_pkg::*;
(
  // Configuration
  input  wire ubcm_cond_t  cond,
  input  wire logic [31:0] brk_addr,
  input  wire logic [31:0] brk_mask,
  // Observed cycle
  input  wire ubcm_cycle_t cyc,
  input  wire logic [31:0] cmp_addr,
  // Result
  output logic             hit
);

  logic addr_ok;
  logic src_ok;
  logic fd_ok;
  logic dir_ok;
  logic sz_ok;
  logic eff_write;
  logic [1:0] eff_size;

  // Masked bits drop out of the comparison
  assign addr_ok = ((cmp_addr ^ brk_addr) & ~brk_mask) == 32'h0000_0000;
  // Each selector: low bit picks the first kind, high bit the second, 00 blocks
  assign src_ok = cyc.dma ? cond.cycle_source_sel[1] : cond.cycle_source_sel[0];
  assign fd_ok  = cyc.fetch ? cond.fetch_data_sel[0] : cond.fetch_data_sel[1];
  // Fetches are always reads, whatever the bus reports
  assign eff_write = cyc.write & ~cyc.fetch;
  assign dir_ok = eff_write ? cond.direction_sel[1] : cond.direction_sel[0];
  // Fetches count as word; data uses the operand size, not the port width
  assign eff_size = cyc.fetch ? `UBCM_SZ_WORD : cyc.size;
  assign sz_ok = (cond.size_sel == `UBCM_SZ_ANY) || (cond.size_sel == eff_size);

  // All terms judged together for the same cycle
  assign hit = cyc.valid & addr_ok & src_ok & fd_ok & dir_ok & sz_ok;

endmodule

// ---- rtl/ubcm_hold.sv ----
// Holds a break request until an interrupt-accepting instruction boundary takes it.
// Assumes the core reports each instruction boundary with its address and mask level.
`timescale 1ns/1ps
`include "ubcm_params.svh"

module ubcm_hold
  import ubcm_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        clear,
  // Match event
  input  wire logic        hit,
  input  wire logic        hit_fetch,
  input  wire logic [31:0] hit_addr,
  // Core side
  input  wire ubcm_exec_t  exec,
  input  wire logic [3:0]  mask_level,
  // Results
  output logic             brk_req,
  output logic             brk_take,
  output logic [31:0]      saved_pc_q,
  output ubcm_hold_st_t    state_q,
  output logic             tgt_fetch_q
);

  ubcm_hold_st_t state_d;
  logic [31:0]   tgt_addr_q;
  logic          level_ok;
  logic          at_tgt;

  assign level_ok = mask_level <= `UBCM_MASK_MAX_OK;
  assign at_tgt   = exec.valid && (exec.pc == tgt_addr_q);
  // Fetch breaks wait for the matched instruction (or a later boundary once deferred)
  always_comb begin
    brk_take = 1'b0;
    if (level_ok && exec.valid && exec.int_ok) begin
      unique case (state_q)
        UBCM_IDLE:  brk_take = 1'b0;
        UBCM_PEND:  brk_take = !tgt_fetch_q || at_tgt;
        UBCM_DEFER: brk_take = 1'b1;
      endcase
    end
  end

  // Request stays high while pending, even at mask level 15
  assign brk_req = state_q != UBCM_IDLE;

  // Next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      UBCM_IDLE:  if (hit) state_d = UBCM_PEND;
      UBCM_PEND: begin
        if (brk_take) state_d = UBCM_IDLE;
        else if (tgt_fetch_q && at_tgt && !exec.int_ok) state_d = UBCM_DEFER;
      end
      UBCM_DEFER: if (brk_take) state_d = UBCM_IDLE;
    endcase
  end

  // State register; hardware standby acts as reset
  always_ff @(posedge clk) begin
    if (reset || clear) begin
      state_q <= UBCM_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Target captured when a new break becomes pending
  always_ff @(posedge clk) begin
    if (reset || clear) begin
      tgt_addr_q  <= `UBCM_RST_32;
      tgt_fetch_q <= 1'b0;
    end else if (state_q == UBCM_IDLE && hit) begin
      tgt_addr_q  <= hit_addr;
      tgt_fetch_q <= hit_fetch;
    end
  end

  // Program counter handed to exception processing
  always_ff @(posedge clk) begin
    if (reset || clear) begin
      saved_pc_q <= `UBCM_RST_32;
    end else if (brk_take) begin
      saved_pc_q <= exec.pc;
    end
  end

endmodule

// ---- test/ubcm_core_model.sv ----
// Model of the core and transfer side: bus cycles, instruction boundaries, mask level.
// Assumes the bench calls its tasks from one process on the matcher clock.
`timescale 1ns/1ps
module ubcm_core_model
  import ubcm_pkg::*;
(
  // Clock
  input  wire logic clk,
  // Toward the matcher
  output ubcm_cycle_t bus_cycle,
  output ubcm_exec_t  exec,
  output logic [3:0]  mask_level
);
  // Quiet lines at time zero
  initial begin
    bus_cycle  = '0;
    exec       = '0;
    mask_level = 4'h0;
  end

  // One bus cycle for one clock; idle carries inverted values so stale data never hits
  task automatic cyc(input logic d, f, w, input logic [1:0] s, input logic p,
                     input logic [31:0] a);
    @(posedge clk);
    bus_cycle <= '{1'b1, d, f, w, s, p, a};
    @(posedge clk);
    bus_cycle <= '{1'b0, ~d, ~f, ~w, ~s, ~p, ~a};
  endtask

  // One instruction boundary, one clock long
  task automatic bnd(input logic [31:0] pc, input logic ok);
    @(posedge clk);
    exec <= '{1'b1, ok, pc};
    @(posedge clk);
    exec <= '{1'b0, ~ok, ~pc};
  endtask

  // Mask level changes only between instructions
  task automatic lvl(input logic [3:0] l);
    @(posedge clk);
    mask_level <= l;
  endtask
endmodule

// ---- test/user_break_condition_matcher_tb_top.sv ----
// Self-checking bench for the break matcher: register port, match table, take and save.
// Assumes the core model in ubcm_core_model.sv and the design under rtl/.
`timescale 1ns/1ps
`include "ubcm_params.svh"
module user_break_condition_matcher_tb_top
  import ubcm_pkg::*;
;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        hw_standby = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  ubcm_cycle_t bus_cycle;
  ubcm_exec_t  exec;
  logic [3:0]  mask_level;
  logic        brk_req;
  logic [3:0]  brk_prio;
  logic        brk_take;
  logic [31:0] saved_pc;
  int          n_fail = 0;
  int          checks = 0;
  int          n_take = 0;
  logic        t;
  logic        e;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  // Count accepted breaks at the edge that takes them
  always @(posedge clk) if (brk_take === 1'b1) n_take++;

  ubcm_top uut (.clk(clk), .reset(reset), .hw_standby(hw_standby), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bus_cycle(bus_cycle), .exec(exec), .interrupt_mask_level(mask_level),
    .brk_req(brk_req), .brk_prio(brk_prio), .brk_take(brk_take), .saved_pc(saved_pc));

  ubcm_core_model core (.clk(clk), .bus_cycle(bus_cycle), .exec(exec),
    .mask_level(mask_level));

  // Verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask

  task automatic cfg(input logic [31:0] a, m, input logic [15:0] c);
    wr(`UBCM_OFF_ADDR_HI, a[31:16]);
    wr(`UBCM_OFF_ADDR_LO, a[15:0]);
    wr(`UBCM_OFF_MASK_HI, m[31:16]);
    wr(`UBCM_OFF_MASK_LO, m[15:0]);
    wr(`UBCM_OFF_COND, c);
  endtask

  // One boundary; reports whether the break was taken there
  task automatic bt(input logic [31:0] pc, input logic ok, output logic took);
    int n0;
    n0 = n_take;
    core.bnd(pc, ok);
    #1 took = (n_take != n0);
  endtask

  // Expected match from the condition fields; a fetch is a word read
  function automatic logic exp_hit(logic [7:0] c, logic d, f, w, logic [1:0] s);
    logic [1:0] se;
    se = f ? 2'h2 : s;
    return (d ? c[7] : c[6]) & (f ? c[4] : c[5]) & ((f ? 1'b0 : w) ? c[3] : c[2])
           & (c[1:0] == 2'h0 || c[1:0] == se);
  endfunction

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    conclude();
  end

  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    for (int a = 0; a < 14; a += 2) rdc(4'(a), 16'h0000);
    chk(brk_prio, 4'hF);
    cfg(32'h0012_3456, 32'hA5A5_5A5A, 16'hFFFF);
    rdc(`UBCM_OFF_COND, 16'h00FF);
    rdc(`UBCM_OFF_ADDR_HI, 16'h0012);
    rdc(`UBCM_OFF_ADDR_LO, 16'h3456);
    rdc(`UBCM_OFF_MASK_LO, 16'h5A5A);
    $display("test registers done");
    // Masked address bits 7:4: flipped masked bits still hit, an unmasked bit misses
    cfg(32'h0012_3456, 32'h0000_00F0, 16'h0066);
    core.cyc(1'b0, 1'b0, 1'b0, 2'h2, 1'b0, 32'h0012_34A6);
    #1 chk(brk_req, 1'b1);
    bt(32'h0000_0200, 1'b1, t);
    core.cyc(1'b0, 1'b0, 1'b0, 2'h2, 1'b0, 32'h0012_3556);
    #1 chk(brk_req, 1'b0);
    $display("test mask done");
    // Every condition code against every cycle kind and size
    wr(`UBCM_OFF_MASK_LO, 16'h0000);
    for (int c = 0; c < 256; c++) begin
      wr(`UBCM_OFF_COND, 16'(c));
      for (int k = 0; k < 24; k++) begin
        e = exp_hit(8'(c), k[0], k[1], k[2], 2'(k / 8 + 1));
        core.cyc(k[0], k[1], k[2], 2'(k / 8 + 1), 1'b0, 32'h0012_3456);
        #1 chk(brk_req, e);
        bt(32'h0012_3456, 1'b1, t);
        chk(t, e);
      end
    end
    $display("test table done");
    // Fetch break held at mask 15, taken at 14 before the instruction
    cfg(32'h0000_0404, 32'h0, 16'h0054);
    core.cyc(1'b0, 1'b1, 1'b0, 2'h2, 1'b0, 32'h0000_0404);
    #1 chk(brk_req, 1'b1);
    core.lvl(4'hF);
    bt(32'h0000_0404, 1'b1, t);
    chk({t, brk_req}, 2'b01);
    rdc(`UBCM_OFF_STATUS, 16'h0005);
    core.lvl(4'hE);
    bt(32'h0000_0404, 1'b1, t);
    chk({t, brk_req}, 2'b10);
    chk(saved_pc, 32'h0000_0404);
    // Boundary that refuses interrupts defers to the next one
    core.cyc(1'b0, 1'b1, 1'b0, 2'h2, 1'b0, 32'h0000_0404);
    bt(32'h0000_0404, 1'b0, t);
    chk(t, 1'b0);
    rdc(`UBCM_OFF_STATUS, 16'h0007);
    bt(32'h0000_0406, 1'b1, t);
    chk(t, 1'b1);
    chk(saved_pc, 32'h0000_0406);
    $display("test fetch done");
    // Second instruction of a paired fetch breaks after the first one
    wr(`UBCM_OFF_ADDR_LO, 16'h0406);
    core.cyc(1'b0, 1'b1, 1'b0, 2'h2, 1'b1, 32'h0000_0404);
    #1 chk(brk_req, 1'b1);
    bt(32'h0000_0404, 1'b1, t);
    chk(t, 1'b0);
    bt(32'h0000_0406, 1'b1, t);
    chk({t, saved_pc}, {1'b1, 32'h0000_0406});
    // Data break saves the next instruction boundary
    cfg(32'h0012_3456, 32'h0, 16'h006A);
    core.cyc(1'b0, 1'b0, 1'b1, 2'h2, 1'b0, 32'h0012_3456);
    bt(32'h0000_0200, 1'b1, t);
    chk({t, saved_pc}, {1'b1, 32'h0000_0200});
    $display("test pair and data done");
    // Hardware standby drops the pending break and clears the registers
    core.cyc(1'b0, 1'b0, 1'b1, 2'h2, 1'b0, 32'h0012_3456);
    @(posedge clk);
    hw_standby <= 1'b1;
    @(posedge clk);
    hw_standby <= 1'b0;
    #1 chk(brk_req, 1'b0);
    rdc(`UBCM_OFF_COND, 16'h0000);
    rdc(`UBCM_OFF_ADDR_HI, 16'h0000);
    $display("test standby done");
    conclude();
  end
endmodule
